// *** rtl/euwp_pref_top.sv ***
// Purpose: Per-port, per-priority unicast/multicast preference registers and pickers
// Assumes: One AXI4-Lite write and one read outstanding at most
// Notes:   Unmapped addresses answer SLVERR, reads of them return zero
//
// How it works
// - Enable clear: no preference, weight ignored
// - Enable set: weight applied to preferred type
// - Type select: zero multicast, one unicast
// - Weight counts preferred packets between others
// - Separate words for groups one to three
// - Eight ports, copies spaced 0x100 apart
// - Words reset zero; reserved bits read zero
// - Group zero word just below group one
//
// The AXI4-Lite register port was decided locally.

`timescale 1ns/10ps

module euwp_pref_top
    import euwp_pkg::*;
#(
    parameter int NUM_PORTS  = EUWP_NUM_PORTS,
    parameter int NUM_GROUPS = EUWP_NUM_GROUPS,
    parameter int NUM_LANES  = NUM_PORTS * NUM_GROUPS
)(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic [EUWP_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [EUWP_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [EUWP_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [EUWP_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [NUM_LANES-1:0]   ucPending,
    input  wire logic [NUM_LANES-1:0]   mcPending,
    input  wire logic [NUM_LANES-1:0]   pktSent,
    input  wire logic [NUM_LANES-1:0]   sentUc,
    output logic      [NUM_LANES-1:0]   pickUc,
    output logic      [NUM_LANES-1:0]   pickMc
);

    localparam int LANE_W = PREF_PORT_W + PREF_GROUP_W;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic addrHit(input logic [EUWP_ADDR_W-1:0] addr);
        return (addr & ~PREF_SELECT_MASK) == PRIO0_CAST_PREFERENCE;
    endfunction

    function automatic logic [LANE_W-1:0] addrLane(input logic [EUWP_ADDR_W-1:0] addr);
        return {addr[PREF_PORT_LSB +: PREF_PORT_W], addr[PREF_GROUP_LSB +: PREF_GROUP_W]};
    endfunction

    // ----------------------------------------------------------------
    // Configuration storage
    // ----------------------------------------------------------------
    logic [NUM_LANES-1:0]     cfgEn;
    logic [NUM_LANES-1:0]     cfgSel;
    logic [EUWP_WEIGHT_W-1:0] cfgWeight [NUM_LANES];
    logic [NUM_LANES-1:0]     restartLane;

    logic [EUWP_ADDR_W-1:0]   wrAddr;
    logic [EUWP_DATA_W-1:0]   wrData;
    logic [3:0]               wrStrb;

    wire                      wrDo     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire                      wrHit    = addrHit(wrAddr);
    wire [LANE_W-1:0]         wrLane   = addrLane(wrAddr);
    wire                      wrCtl    = wrDo && wrHit && wrStrb[ENABLE_LANE];
    wire                      wrWeight = wrDo && wrHit && wrStrb[WEIGHT_LANE];
    wire                      wrOff    = wrCtl && !wrData[ENABLE_BIT];
    wire                      rdTake   = s_axi_arvalid && s_axi_arready;
    wire                      rdHit    = addrHit(s_axi_araddr);
    wire [LANE_W-1:0]         rdLane   = addrLane(s_axi_araddr);
    // Reserved bits are never stored, so they read back as zero
    wire [EUWP_DATA_W-1:0]    rdWord   = (PREF_RESET
                                         | ({{(EUWP_DATA_W-1){1'b0}}, cfgEn[rdLane]} << ENABLE_BIT)
                                         | ({{(EUWP_DATA_W-1){1'b0}}, cfgSel[rdLane]} << TYPE_SEL_BIT)
                                         | ({{(EUWP_DATA_W-EUWP_WEIGHT_W){1'b0}}, cfgWeight[rdLane]}
                                            << WEIGHT_LSB)) & PREF_RW_MASK;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfgEn       <= '0;
            cfgSel      <= '0;
            cfgWeight   <= '{default: '0};
            restartLane <= '0;
        end else begin
            restartLane <= '0;
            if (wrCtl) begin
                cfgEn[wrLane]  <= wrData[ENABLE_BIT];
                cfgSel[wrLane] <= wrData[TYPE_SEL_BIT];
            end
            if (wrWeight) begin
                cfgWeight[wrLane] <= wrData[WEIGHT_LSB +: EUWP_WEIGHT_W];
            end
            if (wrWeight || wrOff) begin
                restartLane[wrLane] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    // Address and data are held separately so either may arrive first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wrAddr        <= '0;
            wrData        <= '0;
            wrStrb        <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wrAddr        <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wrData       <= s_axi_wdata;
                wrStrb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrDo) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (rdTake) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdHit ? rdWord : '0;
                s_axi_rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pickers, one per port and priority group
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_LANES; i++) begin : gLane
        euwp_grp_if grp ();

        assign grp.enable    = cfgEn[i];
        assign grp.typeSel   = cfgSel[i];
        assign grp.weight    = cfgWeight[i];
        assign grp.restart   = restartLane[i];
        assign grp.ucPending = ucPending[i];
        assign grp.mcPending = mcPending[i];
        assign grp.pktSent   = pktSent[i];
        assign grp.sentUc    = sentUc[i];
        assign pickUc[i]     = grp.pickUc;
        assign pickMc[i]     = grp.pickMc;

        euwp_pref_pick uPick (
            .clk    (clk),
            .arst_n (arst_n),
            .grp    (grp)
        );
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    reserved_read_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_axi_rvalid |-> (s_axi_rdata & ~PREF_RW_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    group_words_a: assert property (@(posedge clk) disable iff (!arst_n)
        rdTake && (s_axi_araddr == PRIO1_CAST_PREFERENCE || s_axi_araddr == PRIO2_CAST_PREFERENCE
                   || s_axi_araddr == PRIO3_CAST_PREFERENCE) |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
        else $error("group word not decoded");
    group_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        rdTake && s_axi_araddr == PRIO0_CAST_PREFERENCE |=> s_axi_rresp == RESP_OKAY)
        else $error("group zero word not decoded");
    port_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
        wrCtl |=> cfgEn[$past(wrLane)] == $past(wrData[ENABLE_BIT]) && s_axi_bvalid)
        else $error("port copy not written");
    weight_restart_a: assert property (@(posedge clk) disable iff (!arst_n)
        wrWeight |=> restartLane[$past(wrLane)] ##1 !restartLane[$past(wrLane, 2)])
        else $error("weight write did not restart counter once");

endmodule

// *** rtl/euwp_pkg.sv ***
// Purpose: Shared constants for the egress unicast/multicast weighted preference block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Field positions use conventional numbering, bit 0 = least significant

package euwp_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int EUWP_NUM_PORTS  = 8;
    localparam int EUWP_NUM_GROUPS = 4;
    localparam int EUWP_ADDR_W     = 20;
    localparam int EUWP_DATA_W     = 32;
    localparam int EUWP_WEIGHT_W   = 4;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [19:0] PRIO0_CAST_PREFERENCE = 20'h1b010;
    localparam logic [19:0] PRIO1_CAST_PREFERENCE = 20'h1b014;
    localparam logic [19:0] PRIO2_CAST_PREFERENCE = 20'h1b018;
    localparam logic [19:0] PRIO3_CAST_PREFERENCE = 20'h1b01c;
    // Address bits that select port (stride 0x100) and group (stride 4)
    localparam logic [19:0] PREF_SELECT_MASK      = 20'h0070c;
    localparam int          PREF_PORT_LSB         = 8;
    localparam int          PREF_PORT_W           = 3;
    localparam int          PREF_GROUP_LSB        = 2;
    localparam int          PREF_GROUP_W          = 2;

    // ----------------------------------------------------------------
    // Control word fields
    // ----------------------------------------------------------------
    localparam int          ENABLE_BIT   = 25;
    localparam int          TYPE_SEL_BIT = 24;
    localparam int          WEIGHT_LSB   = 0;
    localparam int          ENABLE_LANE  = 3;
    localparam int          WEIGHT_LANE  = 0;
    localparam logic [31:0] PREF_RESET   = 32'h0000_0000;
    localparam logic [31:0] PREF_RW_MASK = 32'h0300_000f;

    // ----------------------------------------------------------------
    // AXI responses
    // ----------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// *** rtl/euwp_grp_if.sv ***
// Purpose: Carries one priority group's settings and packet traffic to its picker
// Assumes: All signals on the core clock
// Notes:   One instance per port and priority group

`timescale 1ns/10ps

interface euwp_grp_if;
    import euwp_pkg::*;

    logic                     enable;
    logic                     typeSel;
    logic [EUWP_WEIGHT_W-1:0] weight;
    logic                     restart;
    logic                     ucPending;
    logic                     mcPending;
    logic                     pktSent;
    logic                     sentUc;
    logic                     pickUc;
    logic                     pickMc;

    modport ctrl (output enable, typeSel, weight, restart, ucPending, mcPending, pktSent, sentUc,
                  input  pickUc, pickMc);
    modport pick (input  enable, typeSel, weight, restart, ucPending, mcPending, pktSent, sentUc,
                  output pickUc, pickMc);
endinterface

// *** rtl/euwp_pref_pick.sv ***
// Purpose: Chooses unicast or multicast for one priority group of one port
// Assumes: pktSent pulses once per packet handed to the egress port
// Notes:   Pick is registered, so it follows pending and counter by one cycle

`timescale 1ns/10ps

module euwp_pref_pick
    import euwp_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    euwp_grp_if.pick  grp
);

    logic [EUWP_WEIGHT_W-1:0] prefCount;
    logic [EUWP_WEIGHT_W-1:0] next_prefCount;
    logic                     lastUc;
    logic                     pickUc;
    logic                     pickMc;

    // ----------------------------------------------------------------
    // Selection
    // ----------------------------------------------------------------
    wire underWeight  = prefCount < grp.weight;
    // Disabled: plain alternation so neither type is favoured
    wire tieUc        = grp.enable ? (underWeight == grp.typeSel) : ~lastUc;
    wire next_pickUc  = grp.ucPending & (~grp.mcPending | tieUc);
    wire next_pickMc  = grp.mcPending & ~next_pickUc;
    wire sentPref     = grp.pktSent & (grp.sentUc == grp.typeSel);

    // Counter saturates at the weight, so it never wraps past it
    always_comb begin
        if (grp.restart || !grp.enable) begin
            next_prefCount = '0;
        end else if (sentPref) begin
            next_prefCount = underWeight ? prefCount + 1'b1 : prefCount;
        end else if (grp.pktSent) begin
            next_prefCount = '0;
        end else begin
            next_prefCount = prefCount;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prefCount <= '0;
            lastUc    <= 1'b0;
            pickUc    <= 1'b0;
            pickMc    <= 1'b0;
        end else begin
            prefCount <= next_prefCount;
            lastUc    <= grp.pktSent ? grp.sentUc : lastUc;
            pickUc    <= next_pickUc;
            pickMc    <= next_pickMc;
        end
    end

    assign grp.pickUc = pickUc;
    assign grp.pickMc = pickMc;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    disabled_alternate_a: assert property (@(posedge clk) disable iff (!arst_n)
        !grp.enable && grp.ucPending && grp.mcPending |=> pickUc == !$past(lastUc))
        else $error("disabled group did not alternate");
    pref_first_a: assert property (@(posedge clk) disable iff (!arst_n)
        grp.enable && grp.ucPending && grp.mcPending && prefCount < grp.weight
        |=> (pickUc == $past(grp.typeSel)) && (pickMc != $past(grp.typeSel)))
        else $error("preferred type not picked under weight");
    type_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
        grp.enable && !grp.typeSel && grp.mcPending && grp.ucPending && grp.weight != 4'h0
        && prefCount == 4'h0 |=> pickMc && !pickUc)
        else $error("select zero did not prefer multicast");
    weight_spent_a: assert property (@(posedge clk) disable iff (!arst_n)
        grp.enable && grp.ucPending && grp.mcPending && prefCount >= grp.weight
        |=> pickUc != $past(grp.typeSel))
        else $error("other type not picked after weight spent");
    restart_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        grp.restart || !grp.enable |=> prefCount == 4'h0 ##1 prefCount <= 4'h1)
        else $error("counter not restarted");

endmodule

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the unicast/multicast weighted preference block
// Assumes: Bench masters the AXI4-Lite port and plays the egress scheduler on lanes 9, 10 and 30
// Notes:   Lane = port*4 + group; picks are read two edges after their cause settles

`timescale 1ns/10ps

module tb_top;
    import euwp_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and wiring
    // ----------------------------------------------------------------
    logic        clk;
    logic        arst_n;
    logic [19:0] awAddr, arAddr;
    logic        awValid, wValid, bReady, arValid, rReady;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [1:0]  bResp, rResp;
    logic [31:0] rData;
    logic [31:0] ucPending, mcPending, pktSent, sentUc, pickUc, pickMc;
    int          nFail;
    int          checksDone;
    logic [1:0]  resp;
    logic [31:0] word;

    localparam logic [31:0] EN_W = 32'h1 << ENABLE_BIT;
    localparam logic [31:0] UC_W = 32'h1 << TYPE_SEL_BIT;

    euwp_pref_top u_euwp_pref_top (.clk(clk), .arst_n(arst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .ucPending(ucPending), .mcPending(mcPending), .pktSent(pktSent), .sentUc(sentUc),
        .pickUc(pickUc), .pickMc(pickMc));

    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (nFail == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Picks compared as {pickUc, pickMc} of one lane
    task automatic cmp_pick(input int lane, input logic [1:0] exp);
        checksDone++;
        if ({pickUc[lane], pickMc[lane]} !== exp) begin
            nFail++;
            $display("mismatch t=%0t pick got=%h exp=%h", $time, {pickUc[lane], pickMc[lane]}, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // Bus master; each task is entered just after a rising edge
    // ----------------------------------------------------------------
    function automatic logic [19:0] word_addr(input int port, input int grp);
        return PRIO0_CAST_PREFERENCE + 20'(port * 256) + 20'(grp * 4);
    endfunction

    task automatic axi_wr(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int i;
        awAddr <= a; awValid <= 1'b1; wData <= d; wStrb <= s; wValid <= 1'b1; bReady <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid && bReady) begin
                r = bResp;
                bReady <= 1'b0;
                break;
            end
        end
        if (i == 50) begin nFail++; finish_test(); end
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid && rReady) begin
                d = rData;
                r = rResp;
                rReady <= 1'b0;
                break;
            end
        end
        if (i == 50) begin nFail++; finish_test(); end
        @(posedge clk);
    endtask

    // Hands one packet of the given type to the lane, then lets the pick settle
    task automatic send(input int lane, input logic isUc);
        pktSent[lane] <= 1'b1; sentUc[lane] <= isUc;
        @(posedge clk);
        pktSent[lane] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Checks a sequence of picks with both types waiting; 1 = unicast expected
    task automatic run_seq(input int lane, input int n, input logic [7:0] seq);
        for (int i = 0; i < n; i++) begin
            cmp_pick(lane, seq[i] ? 2'b10 : 2'b01);
            send(lane, seq[i]);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic sc_reset_and_map();
        for (int g = 0; g < 4; g++) begin
            axi_rd(word_addr(7, g), word, resp);
            cmp_word(word, PREF_RESET);
            cmp_resp(resp, RESP_OKAY);
            // Port zero words, so the decode checks on the base offsets see traffic
            axi_rd(word_addr(0, g), word, resp);
            cmp_word(word, PREF_RESET);
            cmp_resp(resp, RESP_OKAY);
        end
        // Distinct values per group and per port prove separate copies
        for (int g = 0; g < 4; g++) begin
            axi_wr(word_addr(5, g), 32'h0000_0001 + 32'(g), 4'hf, resp);
            cmp_resp(resp, RESP_OKAY);
        end
        for (int g = 0; g < 4; g++) begin
            axi_rd(word_addr(5, g), word, resp);
            cmp_word(word, 32'h0000_0001 + 32'(g));
            axi_rd(word_addr(4, g), word, resp);
            cmp_word(word, PREF_RESET);
        end
        // Reserved bits never take a one; weight lane alone honours strobe 0
        axi_wr(word_addr(1, 1), 32'hffff_ffff, 4'h1, resp);
        axi_rd(word_addr(1, 1), word, resp);
        cmp_word(word, 32'h0000_000f);
        axi_wr(word_addr(1, 1), 32'hffff_ffff, 4'hf, resp);
        axi_rd(word_addr(1, 1), word, resp);
        cmp_word(word, PREF_RW_MASK);
        axi_wr(20'h1b020, 32'hffff_ffff, 4'hf, resp);
        cmp_resp(resp, RESP_SLVERR);
        axi_rd(20'h1b020, word, resp);
        cmp_word(word, 32'h0);
        cmp_resp(resp, RESP_SLVERR);
    endtask

    task automatic sc_weighted();
        axi_wr(word_addr(2, 1), EN_W | UC_W | 32'h2, 4'hf, resp);
        ucPending[9] <= 1'b1; mcPending[9] <= 1'b1;
        repeat (3) @(posedge clk);
        run_seq(9, 4, 8'b1011);
        // Rewriting the weight restarts the count, so two unicast again
        axi_wr(word_addr(2, 1), EN_W | UC_W | 32'h2, 4'hf, resp);
        repeat (3) @(posedge clk);
        run_seq(9, 3, 8'b011);
        ucPending[9] <= 1'b0;
        repeat (3) @(posedge clk);
        cmp_pick(9, 2'b01);
        // Multicast preferred, weight one
        axi_wr(word_addr(2, 2), EN_W | 32'h1, 4'hf, resp);
        ucPending[10] <= 1'b1; mcPending[10] <= 1'b1;
        repeat (3) @(posedge clk);
        run_seq(10, 4, 8'b1010);
    endtask

    task automatic sc_disabled();
        // Select and weight set but enable clear: plain alternation
        axi_wr(word_addr(7, 2), UC_W | 32'h5, 4'hf, resp);
        ucPending[30] <= 1'b1; mcPending[30] <= 1'b1;
        repeat (3) @(posedge clk);
        run_seq(30, 4, 8'b0101);
        mcPending[30] <= 1'b0;
        repeat (3) @(posedge clk);
        cmp_pick(30, 2'b10);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0; arst_n = 1'b0; nFail = 0; checksDone = 0;
        awAddr = 20'h0; awValid = 1'b0; wData = 32'h0; wStrb = 4'h0; wValid = 1'b0; bReady = 1'b0;
        arAddr = 20'h0; arValid = 1'b0; rReady = 1'b0;
        ucPending = 32'h0; mcPending = 32'h0; pktSent = 32'h0; sentUc = 32'h0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        sc_reset_and_map();
        sc_weighted();
        sc_disabled();
        finish_test();
    end
endmodule
